// >>> logic/rivm_pkg.sv
package rivm_pkg;

	//--------------------------------------------------------------
	// Table geometry
	//--------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int NUM_SRC = 32;
	localparam int IDX_W = 5;

	// Default boot section start (word address), parameter default
	localparam logic [11:0] BOOT_START_DEF = 12'hC00;

	//--------------------------------------------------------------
	// Table entries (word index)
	//--------------------------------------------------------------
	localparam logic [4:0] VEC_RESET = 5'h00;
	localparam logic [4:0] VEC_PS2_CAPT = 5'h01;
	localparam logic [4:0] VEC_PS2_EC = 5'h02;
	localparam logic [4:0] VEC_PS1_CAPT = 5'h03;
	localparam logic [4:0] VEC_PS1_EC = 5'h04;
	localparam logic [4:0] VEC_PS0_CAPT = 5'h05;
	localparam logic [4:0] VEC_PS0_EC = 5'h06;
	localparam logic [4:0] VEC_CMP0 = 5'h07;
	localparam logic [4:0] VEC_CMP1 = 5'h08;
	localparam logic [4:0] VEC_CMP2 = 5'h09;
	localparam logic [4:0] VEC_EXT0 = 5'h0A;
	localparam logic [4:0] VEC_WT_CAPT = 5'h0B;
	localparam logic [4:0] VEC_WT_MA = 5'h0C;
	localparam logic [4:0] VEC_WT_MB = 5'h0D;
	localparam logic [4:0] VEC_FREE_E = 5'h0E;
	localparam logic [4:0] VEC_WT_OVF = 5'h0F;
	localparam logic [4:0] VEC_NT_MA = 5'h10;
	localparam logic [4:0] VEC_NT_OVF = 5'h11;
	localparam logic [4:0] VEC_ADC = 5'h12;
	localparam logic [4:0] VEC_EXT1 = 5'h13;
	localparam logic [4:0] VEC_SPI = 5'h14;
	localparam logic [4:0] VEC_RX = 5'h15;
	localparam logic [4:0] VEC_TXE = 5'h16;
	localparam logic [4:0] VEC_TXC = 5'h17;
	localparam logic [4:0] VEC_EXT2 = 5'h18;
	localparam logic [4:0] VEC_WDT = 5'h19;
	localparam logic [4:0] VEC_NVM = 5'h1A;
	localparam logic [4:0] VEC_NT_MB = 5'h1B;
	localparam logic [4:0] VEC_EXT3 = 5'h1C;
	localparam logic [4:0] VEC_FREE_1D = 5'h1D;
	localparam logic [4:0] VEC_FREE_1E = 5'h1E;
	localparam logic [4:0] VEC_SPM = 5'h1F;

	// Entries with no source attached
	localparam logic [31:0] UNUSED_MASK = 32'h6000_4000;

	//--------------------------------------------------------------
	// Fuse encoding and reset values
	//--------------------------------------------------------------
	localparam logic FUSE_PROGRAMMED = 1'b0;
	localparam logic [11:0] ADDR_RST = 12'h000;

	//--------------------------------------------------------------
	// Sequencer states
	//--------------------------------------------------------------
	typedef enum logic [2:0] {
		RIVM_RESET = 3'b001,
		RIVM_IDLE = 3'b010,
		RIVM_WAIT = 3'b100
	} rivm_state_type;

endpackage

// >>> logic/rivm_prio_enc.sv
`timescale 1ns/1ps
module rivm_prio_enc #(
	parameter int WIDTH = 32,
	parameter int IDX_W = 5
) (
	// Request lines
	input  wire logic [WIDTH-1:0] req,
	// Result
	output logic                  any,
	output logic [IDX_W-1:0]      idx
);

	// Lowest set bit wins
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = IDX_W'(i);
			end
		end
	end

endmodule // rivm_prio_enc

// >>> logic/rivm_vector_map.sv
// Notes on behaviour
// R1: All reset sources fetch reset entry zero.
// R2: Power stage requests use entries one..six.
// R3: Comparators 0,1,2 use entries seven..nine.
// R4: External request 0 at 0x0A, 1 at 0x13.
// R5: External request 2 at 0x18, 3 at 0x1C.
// R6: Wide timer entries 0x0B,0x0C,0x0D,0x0F.
// R7: Narrow timer entries 0x10,0x11,0x1B.
// R8: Converter 0x12, serial peripheral 0x14.
// R9: Serial port entries 0x15,0x16,0x17.
// R10: Watchdog 0x19, data memory 0x1A, programming 0x1F.
// R11: Programmed fuse moves reset to boot start.
// R12: Select bit adds boot start to interrupt entries.
// R13: Select clear keeps table at 0x000.
// R14: Unattached entries never produce a fetch.
// R15: Lowest pending entry is supplied first.
`timescale 1ns/1ps
module rivm_vector_map #(
	parameter logic [11:0] BOOT_START = rivm_pkg::BOOT_START_DEF
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Reset sources
	input  wire logic        ext_reset_pin,
	input  wire logic        power_on_reset,
	input  wire logic        brown_out_reset,
	input  wire logic        watchdog_reset,
	input  wire logic        emulator_reset,
	// Configuration
	input  wire logic        boot_reset_select_fuse,
	input  wire logic        vector_table_select,
	// Power stage requests
	input  wire logic        power_stage_2_capture_irq,
	input  wire logic        power_stage_2_end_cycle_irq,
	input  wire logic        power_stage_1_capture_irq,
	input  wire logic        power_stage_1_end_cycle_irq,
	input  wire logic        power_stage_0_capture_irq,
	input  wire logic        power_stage_0_end_cycle_irq,
	// Comparator and external requests
	input  wire logic        comparator_0_irq,
	input  wire logic        comparator_1_irq,
	input  wire logic        comparator_2_irq,
	input  wire logic        ext_request_0,
	input  wire logic        ext_request_1,
	input  wire logic        ext_request_2,
	input  wire logic        ext_request_3,
	// Timer requests
	input  wire logic        wide_timer_capture_irq,
	input  wire logic        wide_timer_match_a_irq,
	input  wire logic        wide_timer_match_b_irq,
	input  wire logic        wide_timer_overflow_irq,
	input  wire logic        narrow_timer_match_a_irq,
	input  wire logic        narrow_timer_overflow_irq,
	input  wire logic        narrow_timer_match_b_irq,
	// Other peripheral requests
	input  wire logic        adc_complete_irq,
	input  wire logic        spi_complete_irq,
	input  wire logic        serial_rx_complete_irq,
	input  wire logic        serial_tx_buffer_empty_irq,
	input  wire logic        serial_tx_complete_irq,
	input  wire logic        watchdog_timeout_irq,
	input  wire logic        data_nvm_ready_irq,
	input  wire logic        self_program_ready_irq,
	// Core handshake
	input  wire logic        irq_enable,
	input  wire logic        fetch_ack,
	output logic             fetch_req,
	output logic             fetch_is_reset,
	output logic [11:0]      fetch_addr,
	output logic [4:0]       fetch_index
);

	//--------------------------------------------------------------
	// Request vector assembly
	//--------------------------------------------------------------
	logic [31:0] pend;
	logic        any_pend;
	logic [4:0]  win_idx;
	logic        any_reset;
	rivm_pkg::rivm_state_type state;

	// Reset sources merged
	assign any_reset = ext_reset_pin | power_on_reset | brown_out_reset
		| watchdog_reset | emulator_reset; // [R1]

	// Place each source on its entry
	always_comb begin
		pend = '0;
		pend[rivm_pkg::VEC_PS2_CAPT] = power_stage_2_capture_irq; // [R2]
		pend[rivm_pkg::VEC_PS2_EC] = power_stage_2_end_cycle_irq; // [R2]
		pend[rivm_pkg::VEC_PS1_CAPT] = power_stage_1_capture_irq; // [R2]
		pend[rivm_pkg::VEC_PS1_EC] = power_stage_1_end_cycle_irq; // [R2]
		pend[rivm_pkg::VEC_PS0_CAPT] = power_stage_0_capture_irq; // [R2]
		pend[rivm_pkg::VEC_PS0_EC] = power_stage_0_end_cycle_irq; // [R2]
		pend[rivm_pkg::VEC_CMP0] = comparator_0_irq; // [R3]
		pend[rivm_pkg::VEC_CMP1] = comparator_1_irq; // [R3]
		pend[rivm_pkg::VEC_CMP2] = comparator_2_irq; // [R3]
		pend[rivm_pkg::VEC_EXT0] = ext_request_0; // [R4]
		pend[rivm_pkg::VEC_EXT1] = ext_request_1; // [R4]
		pend[rivm_pkg::VEC_EXT2] = ext_request_2; // [R5]
		pend[rivm_pkg::VEC_EXT3] = ext_request_3; // [R5]
		pend[rivm_pkg::VEC_WT_CAPT] = wide_timer_capture_irq; // [R6]
		pend[rivm_pkg::VEC_WT_MA] = wide_timer_match_a_irq; // [R6]
		pend[rivm_pkg::VEC_WT_MB] = wide_timer_match_b_irq; // [R6]
		pend[rivm_pkg::VEC_WT_OVF] = wide_timer_overflow_irq; // [R6]
		pend[rivm_pkg::VEC_NT_MA] = narrow_timer_match_a_irq; // [R7]
		pend[rivm_pkg::VEC_NT_OVF] = narrow_timer_overflow_irq; // [R7]
		pend[rivm_pkg::VEC_NT_MB] = narrow_timer_match_b_irq; // [R7]
		pend[rivm_pkg::VEC_ADC] = adc_complete_irq; // [R8]
		pend[rivm_pkg::VEC_SPI] = spi_complete_irq; // [R8]
		pend[rivm_pkg::VEC_RX] = serial_rx_complete_irq; // [R9]
		pend[rivm_pkg::VEC_TXE] = serial_tx_buffer_empty_irq; // [R9]
		pend[rivm_pkg::VEC_TXC] = serial_tx_complete_irq; // [R9]
		pend[rivm_pkg::VEC_WDT] = watchdog_timeout_irq; // [R10]
		pend[rivm_pkg::VEC_NVM] = data_nvm_ready_irq; // [R10]
		pend[rivm_pkg::VEC_SPM] = self_program_ready_irq; // [R10]
		// Unattached entries forced off
		pend = pend & ~rivm_pkg::UNUSED_MASK; // [R14]
		if (!irq_enable)
			pend = '0;
	end

	// Lowest entry wins
	rivm_prio_enc #(
		.WIDTH (32),
		.IDX_W (5)
	) u_prio (
		.req (pend), // [R15]
		.any (any_pend),
		.idx (win_idx)
	);

	//--------------------------------------------------------------
	// Address computation
	//--------------------------------------------------------------
	function automatic logic [11:0] vec_addr(
		input logic [4:0] idx,
		input logic       rst_entry,
		input logic       fuse,
		input logic       sel
	);
		logic [11:0] base;
		base = 12'h000;
		if (rst_entry)
			base = (fuse == rivm_pkg::FUSE_PROGRAMMED) ? BOOT_START
				: rivm_pkg::ADDR_RST; // [R11]
		else if (sel)
			base = BOOT_START + {7'h00, idx}; // [R12]
		else
			base = {7'h00, idx}; // [R13]
		return base;
	endfunction

	//--------------------------------------------------------------
	// Fetch sequencer
	//--------------------------------------------------------------
	// Reset entry first after any reset; then interrupts
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= rivm_pkg::RIVM_RESET;
			fetch_req <= 1'b0;
			fetch_is_reset <= 1'b0;
			fetch_addr <= 12'h000;
			fetch_index <= 5'h00;
		end else if (any_reset) begin
			state <= rivm_pkg::RIVM_RESET; // [R1]
			fetch_req <= 1'b0;
			fetch_is_reset <= 1'b0;
		end else begin
			case (state)
				rivm_pkg::RIVM_RESET: begin
					fetch_req <= 1'b1;
					fetch_is_reset <= 1'b1;
					fetch_index <= rivm_pkg::VEC_RESET;
					fetch_addr <= vec_addr(rivm_pkg::VEC_RESET, 1'b1,
						boot_reset_select_fuse, vector_table_select); // [R1]
					state <= rivm_pkg::RIVM_WAIT;
				end
				rivm_pkg::RIVM_IDLE: begin
					if (any_pend) begin
						fetch_req <= 1'b1;
						fetch_is_reset <= 1'b0;
						fetch_index <= win_idx;
						fetch_addr <= vec_addr(win_idx, 1'b0,
							boot_reset_select_fuse,
							vector_table_select); // [R12] [R13]
						state <= rivm_pkg::RIVM_WAIT;
					end
				end
				rivm_pkg::RIVM_WAIT: begin
					if (fetch_ack) begin
						fetch_req <= 1'b0;
						fetch_is_reset <= 1'b0;
						state <= rivm_pkg::RIVM_IDLE;
					end
				end
				default: begin
					state <= rivm_pkg::RIVM_RESET;
					fetch_req <= 1'b0;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	property p_reset_first;
		@(posedge clk) disable iff (sys_rst)
		$fell(any_reset) |=> fetch_req && fetch_is_reset;
	endproperty
	a_reset_first: assert property (p_reset_first) // [R1]
		else $error("reset entry not requested after reset");

	property p_reset_addr;
		@(posedge clk) disable iff (sys_rst)
		(fetch_req && fetch_is_reset) |-> fetch_addr ==
			((boot_reset_select_fuse == rivm_pkg::FUSE_PROGRAMMED)
			? BOOT_START : rivm_pkg::ADDR_RST);
	endproperty
	a_reset_addr: assert property (p_reset_addr) // [R11]
		else $error("reset address wrong");

	property p_ext0;
		@(posedge clk) disable iff (sys_rst || any_reset)
		(state == rivm_pkg::RIVM_IDLE && irq_enable && ext_request_0
			&& pend[9:0] == 10'h000)
		|=> fetch_index == rivm_pkg::VEC_EXT0;
	endproperty
	a_ext0: assert property (p_ext0) // [R4]
		else $error("external request 0 entry wrong");

	property p_ps2;
		@(posedge clk) disable iff (sys_rst || any_reset)
		(state == rivm_pkg::RIVM_IDLE && irq_enable
			&& power_stage_2_capture_irq)
		|=> fetch_index == rivm_pkg::VEC_PS2_CAPT;
	endproperty
	a_ps2: assert property (p_ps2) // [R2]
		else $error("power stage entry wrong");

	property p_table_sel;
		@(posedge clk) disable iff (sys_rst)
		(fetch_req && !fetch_is_reset && vector_table_select
			&& $stable(vector_table_select))
		|-> fetch_addr == BOOT_START + {7'h00, fetch_index};
	endproperty
	a_table_sel: assert property (p_table_sel) // [R12]
		else $error("relocated table address wrong");

	property p_table_low;
		@(posedge clk) disable iff (sys_rst)
		(fetch_req && !fetch_is_reset && !vector_table_select
			&& $stable(vector_table_select))
		|-> fetch_addr == {7'h00, fetch_index};
	endproperty
	a_table_low: assert property (p_table_low) // [R13]
		else $error("low table address wrong");

	property p_no_unused;
		@(posedge clk) disable iff (sys_rst)
		(fetch_req && !fetch_is_reset)
		|-> !rivm_pkg::UNUSED_MASK[fetch_index] && fetch_index != 5'h00;
	endproperty
	a_no_unused: assert property (p_no_unused) // [R14]
		else $error("fetch to unattached entry");

	property p_lowest;
		@(posedge clk) disable iff (sys_rst || any_reset)
		(state == rivm_pkg::RIVM_IDLE && any_pend)
		|=> fetch_req && (pend & ((32'h1 << fetch_index) - 32'h1)) == 0
			|| $changed(pend);
	endproperty
	a_lowest: assert property (p_lowest) // [R15]
		else $error("lower pending entry skipped");

	property p_hold;
		@(posedge clk) disable iff (sys_rst || any_reset)
		(fetch_req && !fetch_ack) |=> fetch_req && $stable(fetch_addr);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request dropped before ack");

	c_reset: cover property (@(posedge clk) disable iff (sys_rst)
		fetch_req && fetch_is_reset && fetch_ack);
	c_irq: cover property (@(posedge clk) disable iff (sys_rst)
		fetch_req && !fetch_is_reset && fetch_ack);
	c_sel: cover property (@(posedge clk) disable iff (sys_rst)
		fetch_req && !fetch_is_reset && vector_table_select);
	c_boot: cover property (@(posedge clk) disable iff (sys_rst)
		fetch_req && fetch_is_reset && !boot_reset_select_fuse);

endmodule // rivm_vector_map

// >>> tb/rivm_core_model.sv
`timescale 1ns/1ps
module rivm_core_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Fetch handshake
	input  wire logic       fetch_req,
	input  wire logic [2:0] ack_wait,
	output logic            fetch_ack
);
	logic [2:0] waited;

	// Accept a vector after ack_wait cycles, acknowledge for one cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_ack <= 1'b0;
			waited    <= 3'h0;
		end else if (fetch_ack) begin
			fetch_ack <= 1'b0;
			waited    <= 3'h0;
		end else if (fetch_req) begin
			if (waited == ack_wait)
				fetch_ack <= 1'b1;
			else
				waited <= waited + 3'h1;
		end
	end
endmodule // rivm_core_model

// >>> tb/rivm_vector_map_bench.sv
`timescale 1ns/1ps
module rivm_vector_map_bench;
	localparam logic [11:0] BOOT     = 12'hC00;
	localparam logic [31:0] ATTACHED = 32'h9FFF_BFFE;
	logic        clk, sys_rst, fuse, sel, irq_en, ack, req, is_rst;
	logic [4:0]  rs, idx;
	logic [31:0] irq;
	logic [2:0]  ack_wait;
	logic [11:0] addr;
	int          errors, checks;

	//--------------------------------------------------------------
	// Block and core model
	//--------------------------------------------------------------
	rivm_vector_map #(.BOOT_START(BOOT)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .ext_reset_pin(rs[0]),
		.power_on_reset(rs[1]), .brown_out_reset(rs[2]),
		.watchdog_reset(rs[3]), .emulator_reset(rs[4]),
		.boot_reset_select_fuse(fuse), .vector_table_select(sel),
		.power_stage_2_capture_irq(irq[1]),
		.power_stage_2_end_cycle_irq(irq[2]),
		.power_stage_1_capture_irq(irq[3]),
		.power_stage_1_end_cycle_irq(irq[4]),
		.power_stage_0_capture_irq(irq[5]),
		.power_stage_0_end_cycle_irq(irq[6]),
		.comparator_0_irq(irq[7]), .comparator_1_irq(irq[8]),
		.comparator_2_irq(irq[9]), .ext_request_0(irq[10]),
		.ext_request_1(irq[19]), .ext_request_2(irq[24]),
		.ext_request_3(irq[28]), .wide_timer_capture_irq(irq[11]),
		.wide_timer_match_a_irq(irq[12]), .wide_timer_match_b_irq(irq[13]),
		.wide_timer_overflow_irq(irq[15]),
		.narrow_timer_match_a_irq(irq[16]),
		.narrow_timer_overflow_irq(irq[17]),
		.narrow_timer_match_b_irq(irq[27]), .adc_complete_irq(irq[18]),
		.spi_complete_irq(irq[20]), .serial_rx_complete_irq(irq[21]),
		.serial_tx_buffer_empty_irq(irq[22]),
		.serial_tx_complete_irq(irq[23]), .watchdog_timeout_irq(irq[25]),
		.data_nvm_ready_irq(irq[26]), .self_program_ready_irq(irq[31]),
		.irq_enable(irq_en), .fetch_ack(ack), .fetch_req(req),
		.fetch_is_reset(is_rst), .fetch_addr(addr), .fetch_index(idx)
	);

	rivm_core_model u_core (
		.clk(clk), .sys_rst(sys_rst), .fetch_req(req),
		.ack_wait(ack_wait), .fetch_ack(ack)
	);

	//--------------------------------------------------------------
	// Shared tasks
	//--------------------------------------------------------------
	// Compare one value and count it
	task chk(input string what, input logic [11:0] exp,
			input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Wait for one vector fetch, judge it, withdraw its source
	task fetch(input logic [4:0] e, input logic r, input logic [11:0] a);
		int n;
		n = 0;
		while (req !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("fetch_req", 12'h001, {11'h0, req});
		chk("fetch_is_reset", {11'h0, r}, {11'h0, is_rst});
		chk("fetch_index", {7'h0, e}, {7'h0, idx});
		chk("fetch_addr", a, addr);
		@(posedge clk) irq[e] <= 1'b0;
		n = 0;
		while (req !== 1'b0 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("fetch_req released", 12'h000, {11'h0, req});
	endtask

	//--------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------
	// Raise each entry of a mask in turn and judge its fetch
	task t_set(input logic [31:0] m, input logic s);
		for (int e = 1; e < 32; e++) begin
			if (m[e]) begin
				@(posedge clk) irq[e] <= 1'b1;
				fetch(5'(e), 1'b0,
					(s ? BOOT : 12'h000) + 12'(e));
			end
		end
	endtask

	// Every attached source under every fuse and select setting
	task t_table;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk) begin
				fuse     <= c[1];
				sel      <= c[0];
				ack_wait <= 3'(c * 2);
			end
			t_set(32'h0000_007E, c[0]);
			t_set(32'h0000_0380, c[0]);
			t_set(32'h0008_0400, c[0]);
			t_set(32'h1100_0000, c[0]);
			t_set(32'h0000_B800, c[0]);
			t_set(32'h0803_0000, c[0]);
			t_set(32'h0014_0000, c[0]);
			t_set(32'h00E0_0000, c[0]);
			t_set(32'h8600_0000, c[0]);
		end
	endtask

	// Each reset source, fuse unprogrammed then programmed
	task t_resets;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk) begin
				rs[i % 5] <= 1'b1;
				fuse      <= (i < 5);
			end
			repeat (2) @(posedge clk);
			#1 chk("fetch_req in reset", 12'h000, {11'h0, req});
			@(posedge clk) rs <= 5'h00;
			fetch(5'h00, 1'b1, (i < 5) ? 12'h000 : BOOT);
		end
	endtask

	// All sources at once come out lowest first, gaps skipped
	task t_prio;
		@(posedge clk) begin
			sel <= 1'b0;
			irq <= ATTACHED;
		end
		for (int e = 1; e < 32; e++) begin
			if (ATTACHED[e])
				fetch(5'(e), 1'b0, 12'(e));
		end
	endtask

	// Masked requests wait until enabled
	task t_mask;
		@(posedge clk) begin
			irq_en   <= 1'b0;
			irq[10]  <= 1'b1;
		end
		repeat (20) begin
			@(posedge clk);
			#1 chk("fetch_req masked", 12'h000, {11'h0, req});
		end
		@(posedge clk) irq_en <= 1'b1;
		fetch(5'h0A, 1'b0, 12'h00A);
	endtask

	// Print the verdict and stop
	task close_out;
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	//--------------------------------------------------------------
	// Clock, sequence and watchdog
	//--------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		sys_rst  = 1'b1;
		fuse     = 1'b1;
		sel      = 1'b0;
		irq_en   = 1'b1;
		rs       = 5'h00;
		irq      = 32'h0000_0000;
		ack_wait = 3'h0;
		errors   = 0;
		checks   = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		fetch(5'h00, 1'b1, 12'h000);
		t_table;
		t_resets;
		t_prio;
		t_mask;
		close_out;
	end

	// Cut a hang short
	initial begin
		repeat (8000) @(posedge clk);
		errors++;
		close_out;
	end
endmodule // rivm_vector_map_bench
